// *** design/sds_bank.sv ***
/*
 * one 64-column bank of the zero-suppression scan: encodes runs of hits,
 * then extracts up to six groups lowest column first, one per scan step.
 * assumes line_start and scan_step come from the sequencer, synchronous to clk.
 */
`timescale 1ns/1ns
module sds_bank
#(
    parameter logic [sds_pkg::ID_W-1:0] BANK_ID = 5'h00
)
(
    input  wire logic                                  clk,
    input  wire logic                                  rst_n,
    input  wire logic [sds_pkg::BANK_COLS-1:0]         pixels,
    input  wire logic                                  next_first,
    input  wire logic                                  line_start,
    input  wire logic                                  scan_step,
    input  wire logic                                  take,
    output logic                                       idle,
    output logic                                       done,
    output logic      [sds_pkg::RESULT_W-1:0]          result
);

    typedef struct packed
    {
        sds_pkg::bank_state_e                           st;
        logic [sds_pkg::BANK_COLS-1:0]                  mask;
        logic [2*sds_pkg::BANK_COLS-1:0]                code;
        logic [2:0]                                     steps;
        logic [sds_pkg::COUNT_W-1:0]                    count;
        logic [sds_pkg::MAX_GROUPS*sds_pkg::GROUP_W-1:0] groups;
        logic                                           overlap;
    } bank_s;

    bank_s q;
    bank_s d;
    logic [sds_pkg::BANK_COLS-1:0] snap_q;

    // start flags and run codes; a fifth hit in a row opens a new group
    function automatic logic [3*sds_pkg::BANK_COLS-1:0] encode(input logic [sds_pkg::BANK_COLS-1:0] h);
        logic [sds_pkg::BANK_COLS-1:0]   en;
        logic [2*sds_pkg::BANK_COLS-1:0] cd;
        logic [2:0]                      run;
        int                              s;
        en  = '0;
        cd  = '0;
        run = 3'h0;
        s   = 0;
        for (int i = 0; i < sds_pkg::BANK_COLS; i++)
        begin
            if (!h[i])
                run = 3'h0;
            else if (run == 3'h0 || run == 3'(sds_pkg::MAX_RUN))
            begin
                en[i] = 1'b1;
                s     = i;
                run   = 3'h1;
            end
            else
            begin
                cd[2*s +: 2] = cd[2*s +: 2] + 2'h1;
                run          = run + 3'h1;
            end
        end
        return {cd, en};
    endfunction

    // priority pick of the lowest flagged column, found bit on top
    function automatic logic [sds_pkg::COL_W:0] lowest(input logic [sds_pkg::BANK_COLS-1:0] m);
        logic [sds_pkg::COL_W:0] r;
        r = '0;
        for (int i = sds_pkg::BANK_COLS - 1; i >= 0; i--)
        begin
            if (m[i])
                r = {1'b1, 6'(i)};
        end
        return r;
    endfunction

    logic [3*sds_pkg::BANK_COLS-1:0] enc;
    logic [sds_pkg::COL_W:0]         pick;
    logic [sds_pkg::COL_W-1:0]       col;

    // load, scan and hold sequence
    always_comb
    begin
        d    = q;
        enc  = encode(pixels);
        pick = lowest(q.mask);
        col  = pick[sds_pkg::COL_W-1:0];
        unique case (q.st)
            sds_pkg::BANK_IDLE:
                if (line_start)
                begin
                    d.mask    = enc[sds_pkg::BANK_COLS-1:0];
                    d.code    = enc[3*sds_pkg::BANK_COLS-1:sds_pkg::BANK_COLS];
                    d.count   = sds_pkg::COUNT_RESET;
                    d.groups  = '0;
                    d.steps   = 3'h0;
                    d.overlap = pixels[sds_pkg::BANK_COLS-1] & next_first;
                    d.st      = sds_pkg::BANK_SCAN;
                end
            sds_pkg::BANK_SCAN:
                if (scan_step)
                begin
                    if (pick[sds_pkg::COL_W])
                    begin
                        d.groups[sds_pkg::GROUP_W*int'(q.count) +: sds_pkg::GROUP_W] =
                            {col, q.code[2*int'(col) +: 2]};
                        d.mask[col] = 1'b0;
                        d.count     = q.count + 3'h1;
                    end
                    d.steps = q.steps + 3'h1;
                    if (q.steps == 3'(sds_pkg::MAX_GROUPS - 1))
                        d.st = sds_pkg::BANK_HOLD;
                end
            sds_pkg::BANK_HOLD:
                if (take)
                    d.st = sds_pkg::BANK_IDLE;
        endcase
    end

    // state register and the line copy kept for checking
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q      <= '{st: sds_pkg::BANK_IDLE, count: sds_pkg::COUNT_RESET, default: '0};
            snap_q <= '0;
        end
        else
        begin
            q <= d;
            if (q.st == sds_pkg::BANK_IDLE && line_start)
                snap_q <= pixels;
        end
    end

    assign idle   = (q.st == sds_pkg::BANK_IDLE);
    assign done   = (q.st == sds_pkg::BANK_HOLD);
    assign result = {BANK_ID, q.overlap, q.groups, q.count};

    // stored groups are real hit runs, ascending, with the right length
    function automatic logic groups_ok(input logic [sds_pkg::MAX_GROUPS*sds_pkg::GROUP_W-1:0] g,
                                       input logic [sds_pkg::COUNT_W-1:0] n,
                                       input logic [sds_pkg::BANK_COLS-1:0] h);
        logic ok;
        int   c;
        int   l;
        int   prev;
        ok   = 1'b1;
        prev = -1;
        for (int k = 0; k < sds_pkg::MAX_GROUPS; k++)
        begin
            if (k < int'(n))
            begin
                c = int'(g[k*sds_pkg::GROUP_W + sds_pkg::COL_LSB +: sds_pkg::COL_W]);
                l = int'(g[k*sds_pkg::GROUP_W + sds_pkg::CODE_LSB +: sds_pkg::CODE_W]);
                if (c <= prev || c + l >= sds_pkg::BANK_COLS)
                    ok = 1'b0;
                else
                begin
                    for (int j = 0; j <= l; j++)
                        if (!h[c + j])
                            ok = 1'b0;
                    // a short run must end on a column without a hit
                    if (l < 3 && c + l + 1 < sds_pkg::BANK_COLS && h[c + l + 1])
                        ok = 1'b0;
                end
                prev = c;
            end
        end
        return ok;
    endfunction

    a_groups_sorted_hits: assert property (@(posedge clk) disable iff (!rst_n)
        done |-> groups_ok(q.groups, q.count, snap_q))
        else $error("stored groups are not ascending hit runs");

    a_scan_six_steps: assert property (@(posedge clk) disable iff (!rst_n)
        (idle && line_start) ##1 (scan_step && !done) [*6] |=> done)
        else $error("bank did not finish after six scan steps");

    a_start_clears: assert property (@(posedge clk) disable iff (!rst_n)
        (idle && line_start) |=> (q.count == 3'h0 && q.groups == '0))
        else $error("count or groups not cleared at line start");

    a_flag_on_hit: assert property (@(posedge clk) disable iff (!rst_n)
        (idle && line_start) |=> ((q.mask & ~$past(pixels)) == '0 && (q.mask[0] == $past(pixels[0]))))
        else $error("group start flag on a column without a hit");

    a_count_bound: assert property (@(posedge clk) disable iff (!rst_n)
        (q.st == sds_pkg::BANK_SCAN && scan_step && lowest(q.mask) == '0) |=> $stable(q.count))
        else $error("count moved on a step with no group left");

endmodule

// *** include/sds_pkg.sv ***
/*
 * constants and types shared by the line hit scan and its banks:
 * line geometry, group word layout, packed bank result layout, bank states.
 * assumes nothing of its surroundings; compiled before the design files.
 */
package sds_pkg;

    // line geometry
    localparam int LINE_PIXELS = 960;
    localparam int BANKS       = 15;
    localparam int BANK_COLS   = 64;
    localparam int MAX_GROUPS  = 6;
    localparam int MAX_RUN     = 4;

    // field widths
    localparam int COL_W   = 6;
    localparam int CODE_W  = 2;
    localparam int GROUP_W = CODE_W + COL_W;
    localparam int COUNT_W = 3;
    localparam int ID_W    = 5;

    // bank result layout, lsb first
    localparam int COUNT_LSB   = 0;
    localparam int GROUP_LSB   = COUNT_LSB + COUNT_W;
    localparam int OVERLAP_POS = GROUP_LSB + MAX_GROUPS * GROUP_W;
    localparam int ID_LSB      = OVERLAP_POS + 1;
    localparam int RESULT_W    = ID_LSB + ID_W;

    // inside one group word: code low, column high
    localparam int CODE_LSB = 0;
    localparam int COL_LSB  = CODE_W;

    // output buffer
    localparam int BUF_DEPTH = 2;

    // reset values
    localparam logic [COUNT_W-1:0] COUNT_RESET = 3'h0;
    localparam logic [1:0]         SYNC_RESET  = 2'h0;

    typedef enum logic [2:0]
    {
        BANK_IDLE = 3'h1,
        BANK_SCAN = 3'h2,
        BANK_HOLD = 3'h4
    } bank_state_e;

endpackage

// *** design/sparse_line_hit_scan.sv ***
/*
 * zero-suppression stage for one 960-pixel line: fifteen banks scan in
 * parallel and the packed line result passes through a two-entry buffer.
 * assumes the sequencer drives line_start and scan_step on ref_clk and
 * waits for line_ready; the downstream stage takes words by out_valid/out_ready.
 */
//
// Overview of operation
// - a 960-pixel line splits into fifteen banks of 64 columns
// - a pixel is a hit when its discriminator output is one
// - up to four adjacent hits form one group: first address plus code
// - each column gets a group-start flag, set only on a group's first hit
// - groups in a bank are picked one per step by priority
// - at most six groups per bank per line; six steps only
// - each step decodes the column of the picked start flag
// - a group word is 6-bit column plus 2-bit length code
// - each bank stores up to six 8-bit group words per line
// - each bank keeps a 3-bit count of groups found
// - each bank carries its own fixed 5-bit identifier
// - per line each bank gives count, six group words, overlap flag
// - all fifteen banks run together, up to ninety words per line
// - bank result: count lowest, then per group code then column
`timescale 1ns/1ns
module sparse_line_hit_scan
#(
    parameter int LINE_PIXELS = sds_pkg::LINE_PIXELS,
    parameter int BANKS       = sds_pkg::BANKS,
    parameter int BUF_DEPTH   = sds_pkg::BUF_DEPTH
)
(
    input  wire logic                                   ref_clk,
    input  wire logic                                   reset_n,
    input  wire logic [LINE_PIXELS-1:0]                 line_pixels,
    input  wire logic                                   line_start,
    input  wire logic                                   scan_step,
    output logic                                        line_ready,
    output logic                                        out_valid,
    input  wire logic                                   out_ready,
    output logic      [BANKS*sds_pkg::RESULT_W-1:0]     out_data
);

    localparam int WORD_W = BANKS * sds_pkg::RESULT_W;
    localparam int PTR_W  = $clog2(BUF_DEPTH);
    localparam int CNT_W  = $clog2(BUF_DEPTH + 1);

    // refuse geometry the banks cannot cover
    if (LINE_PIXELS != BANKS * sds_pkg::BANK_COLS || BANKS > 32)
        $error("line must be whole 64-column banks, at most 32 of them");
    if (BUF_DEPTH < 2)
        $error("buffer needs at least two entries");

    typedef struct packed
    {
        logic [BUF_DEPTH-1:0][WORD_W-1:0] mem;
        logic [PTR_W-1:0]                 wr;
        logic [PTR_W-1:0]                 rd;
        logic [CNT_W-1:0]                 cnt;
    } buf_s;

    buf_s                 q;
    buf_s                 d;
    logic [1:0]           sync_q;
    logic                 rst_n;
    logic [BANKS-1:0]     bank_idle;
    logic [BANKS-1:0]     bank_done;
    logic [WORD_W-1:0]    line_word;
    logic                 full;
    logic                 take;
    logic                 pop;

    // reset release through two flops
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            sync_q <= sds_pkg::SYNC_RESET;
        else
            sync_q <= {sync_q[0], 1'b1};
    end

    assign rst_n = sync_q[1];

    // fifteen banks side by side on the same strobes
    for (genvar b = 0; b < BANKS; b++)
    begin : g_bank
        logic nf;
        if (b < BANKS - 1)
        begin : g_nf
            assign nf = line_pixels[(b+1)*sds_pkg::BANK_COLS];
        end
        else
        begin : g_last
            assign nf = 1'b0;
        end
        sds_bank
        #(
            .BANK_ID    (5'(b))
        )
        u_bank
        (
            .clk        (ref_clk),
            .rst_n      (rst_n),
            .pixels     (line_pixels[b*sds_pkg::BANK_COLS +: sds_pkg::BANK_COLS]),
            .next_first (nf),
            .line_start (line_start),
            .scan_step  (scan_step),
            .take       (take),
            .idle       (bank_idle[b]),
            .done       (bank_done[b]),
            .result     (line_word[b*sds_pkg::RESULT_W +: sds_pkg::RESULT_W])
        );
    end

    // a finished line waits in the banks while the buffer is full
    assign full       = (q.cnt == CNT_W'(BUF_DEPTH));
    assign take       = (&bank_done) & ~full;
    assign pop        = out_valid & out_ready;
    assign line_ready = &bank_idle;
    assign out_valid  = (q.cnt != '0);
    assign out_data   = q.mem[q.rd];

    // buffer next state
    always_comb
    begin
        d = q;
        if (take)
        begin
            d.mem[q.wr] = line_word;
            d.wr        = (q.wr == PTR_W'(BUF_DEPTH - 1)) ? '0 : q.wr + 1'b1;
        end
        if (pop)
            d.rd = (q.rd == PTR_W'(BUF_DEPTH - 1)) ? '0 : q.rd + 1'b1;
        d.cnt = q.cnt + CNT_W'(take) - CNT_W'(pop);
    end

    // buffer register
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            q <= '0;
        else
            q <= d;
    end

    a_banks_lockstep: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (&bank_done) == (|bank_done) && (&bank_idle) == (|bank_idle))
        else $error("banks drifted apart");

    a_take_to_valid: assert property (@(posedge ref_clk) disable iff (!rst_n)
        take |=> out_valid && !(&bank_done))
        else $error("finished line did not enter the buffer");

    a_full_stalls: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (&bank_done && full && !out_ready) |=> (&bank_done) && $stable(line_word))
        else $error("line result lost while buffer full");

    a_head_stable: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (out_valid && !out_ready) |=> out_valid && $stable(out_data))
        else $error("head word changed under stall");

    a_line_accept: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (line_ready && line_start) |=> !line_ready ##0 !(&bank_done))
        else $error("line start not taken by the banks");

    // every bank result carries its index and a count of at most six
    for (genvar b = 0; b < BANKS; b++)
    begin : g_chk
        a_bank_id_count: assert property (@(posedge ref_clk) disable iff (!rst_n)
            out_valid |-> (out_data[b*sds_pkg::RESULT_W + sds_pkg::ID_LSB +: sds_pkg::ID_W] == 5'(b)
                && out_data[b*sds_pkg::RESULT_W + sds_pkg::COUNT_LSB +: sds_pkg::COUNT_W] <= 3'h6))
            else $error("bank identifier or count wrong");
    end

endmodule

// *** verif/sds_partner_model.sv ***
/*
 * stand-in for the line sequencer and the downstream stage of the hit scan.
 * assumes the bench pulses go for one cycle on a falling edge; rude lets a
 * start through while the block is busy, stall holds out_ready low.
 */
`timescale 1ns/1ns
module sds_partner_model
(
    input  wire logic ref_clk,
    input  wire logic line_ready,
    input  wire logic go,
    input  wire logic rude,
    input  wire logic stall,
    output logic      line_start,
    output logic      scan_step,
    output logic      out_ready
);
    int steps_left = 0;

    // downstream acceptance follows the stall request
    assign out_ready = ~stall;

    // one start strobe, then exactly six step strobes, changed on falling edges
    initial line_start = 1'h0;
    initial scan_step = 1'h0;
    always @(negedge ref_clk)
    begin
        line_start <= 1'h0;
        scan_step  <= 1'h0;
        if (steps_left != 0)
        begin
            scan_step  <= 1'h1;
            steps_left <= steps_left - 1;
        end
        else if (go && (line_ready || rude))
        begin
            line_start <= 1'h1;
            steps_left <= 6;
        end
    end
endmodule

// *** verif/test_sparse_line_hit_scan.sv ***
/*
 * self-checking bench of the line hit scan: lines of chosen hit patterns,
 * a reference packing per bank, output words compared in order of arrival.
 * assumes sds_pkg, the design and the partner model are compiled first.
 */
`timescale 1ns/1ns
module test_sparse_line_hit_scan;
    localparam int R = sds_pkg::RESULT_W;
    typedef logic [sds_pkg::BANKS*sds_pkg::RESULT_W-1:0] word_t;
    typedef logic [sds_pkg::LINE_PIXELS-1:0]             line_t;

    logic  ref_clk     = 1'h0;
    logic  reset_n     = 1'h0;
    line_t line_pixels = '0;
    logic  go          = 1'h0;
    logic  rude        = 1'h0;
    logic  stall       = 1'h0;
    logic  line_start;
    logic  scan_step;
    logic  line_ready;
    logic  out_valid;
    logic  out_ready;
    word_t out_data;
    word_t exp_q[$];
    int    n_errors    = 0;
    int    n_compared  = 0;
    int    cycles      = 0;

    // 100 MHz clock
    always #5 ref_clk = ~ref_clk;

    sparse_line_hit_scan dut_u
    (
        .ref_clk     (ref_clk),
        .reset_n     (reset_n),
        .line_pixels (line_pixels),
        .line_start  (line_start),
        .scan_step   (scan_step),
        .line_ready  (line_ready),
        .out_valid   (out_valid),
        .out_ready   (out_ready),
        .out_data    (out_data)
    );

    sds_partner_model partner_u
    (
        .ref_clk    (ref_clk),
        .line_ready (line_ready),
        .go         (go),
        .rude       (rude),
        .stall      (stall),
        .line_start (line_start),
        .scan_step  (scan_step),
        .out_ready  (out_ready)
    );

    // reference packing: runs split after four hits, six groups kept per bank
    function automatic word_t ref_word(input line_t px);
        word_t w;
        int    found;
        int    run;
        int    s;
        w = '0;
        s = 0;
        for (int b = 0; b < sds_pkg::BANKS; b++)
        begin
            found = 0;
            run = 0;
            for (int c = 0; c < sds_pkg::BANK_COLS; c++)
            begin
                if (px[b*64+c] === 1'h1)
                begin
                    if (run == 0 || run == 4)
                    begin
                        found++;
                        run = 0;
                        s = c;
                    end
                    run++;
                    if (found <= 6)
                        w[b*R+sds_pkg::GROUP_LSB+8*(found-1) +: 8] = {6'(s), 2'(run - 1)};
                end
                else
                    run = 0;
            end
            w[b*R +: 3] = 3'((found > 6) ? 6 : found);
            if (b < sds_pkg::BANKS - 1)
                w[b*R+sds_pkg::OVERLAP_POS] = px[b*64+63] & px[b*64+64];
            w[b*R+sds_pkg::ID_LSB +: 5] = 5'(b);
        end
        return w;
    endfunction

    task automatic check_word(input string name, input word_t exp, input word_t got);
        n_compared++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check_bit(input string name, input logic exp, input logic got);
        n_compared++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %s expected %b seen %b", name, exp, got);
        end
    endtask

    // every accepted word is checked against the oldest expectation
    always @(posedge ref_clk)
    begin
        if (out_valid === 1'h1 && out_ready === 1'h1)
        begin
            if (exp_q.size() == 0)
                check_bit("unexpected word", 1'h0, 1'h1);
            else
                check_word("out_data", exp_q.pop_front(), out_data);
        end
    end

    // sends one line once the block is ready; entered on a falling edge
    task automatic send_line(input line_t px, input bit expect_it);
        int k;
        k = 0;
        while (line_ready !== 1'h1 && k < 2000)
        begin
            @(negedge ref_clk);
            k++;
        end
        line_pixels <= px;
        go <= 1'h1;
        if (expect_it)
            exp_q.push_back(ref_word(px));
        @(negedge ref_clk);
        go <= 1'h0;
        repeat (8) @(negedge ref_clk);
    endtask

    // drains the buffer with the receiver stalling every other cycle
    task automatic drain;
        int k;
        k = 0;
        while (exp_q.size() != 0 && k < 2000)
        begin
            stall <= ~stall;
            @(negedge ref_clk);
            k++;
        end
        stall <= 1'h0;
        @(negedge ref_clk);
        check_bit("all words seen", 1'h1, logic'(exp_q.size() == 0));
    endtask

    task automatic t_reset;
        check_bit("line_ready after reset", 1'h1, line_ready);
        check_bit("out_valid after reset", 1'h0, out_valid);
    endtask

    task automatic t_runs;
        line_t px;
        px = '0;
        px[0] = 1'h1;
        px[4:3] = 2'h3;
        px[10:8] = 3'h7;
        px[17:14] = 4'hF;
        px[24:20] = 5'h1F;
        px[127] = 1'h1;
        px[128] = 1'h1;
        px[192] = 1'h1;
        px[255] = 1'h1;
        px[959] = 1'h1;
        send_line(px, 1'h1);
        drain;
    endtask

    task automatic t_many;
        line_t px;
        px = '0;
        for (int c = 0; c < 18; c += 2)
            px[320+c] = 1'h1;
        send_line(px, 1'h1);
        send_line('1, 1'h1);
        send_line('0, 1'h1);
        drain;
    endtask

    task automatic t_stall;
        line_t px;
        px = '0;
        px[700] = 1'h1;
        stall <= 1'h1;
        send_line('1, 1'h1);
        send_line(px, 1'h1);
        send_line('0, 1'h1);
        repeat (20) @(negedge ref_clk);
        check_bit("line_ready while full", 1'h0, line_ready);
        check_bit("out_valid while full", 1'h1, out_valid);
        rude <= 1'h1;
        send_line(px, 1'h0);
        rude <= 1'h0;
        drain;
    endtask

    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // hang guard
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            test_done;
        end
    end

    initial
    begin
        repeat (10) @(negedge ref_clk);
        reset_n <= 1'h1;
        repeat (3) @(negedge ref_clk);
        t_reset;
        t_runs;
        t_many;
        t_stall;
        test_done;
    end
endmodule
